// *** hdl/coex_core.sv ***
// Purpose: executes a subset of an 8-bit core's operations over AHB-Lite
// Assumes: one instruction cycle per clock; single word transfers only
// Notes: a command write is one fetched instruction
//
// Contract
// - watchdog clear loads the watchdog count with zero.
// - watchdog clear also zeroes the watchdog prescaler.
// - watchdog clear sets active-low power-down bit, and timeout bit unless the count wraps that cycle.
// - call via accumulator pushes program counter plus one onto stack.
// - call loads pc[7:0] from accumulator, pc[14:8] from latch; no flags.
// - call via accumulator takes two instruction cycles.
// - complement inverts file register; dest 0 accumulator, 1 file; sets zero.
// - file clear writes zero to register 0..127 and sets zero flag.
// - decrement subtracts one; dest selects accumulator or file; zero flag.
// - accumulator clear writes zero and sets the zero flag.
// - decrement-skip subtracts one, routes by dest, flags unchanged.
// - zero result discards the next instruction, running a no-op instead.
`timescale 1ns/1ps
module coex_core
    import coex_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // core state
    output logic [7:0] acc,
    output logic zero_flag,
    output logic dog_expiry_status_n,
    output logic sleep_entry_status_n
);
    coex_state_type s_r;
    coex_state_type s_nxt;

    // eight-bit zero test used by the complement, decrement and decrement-skip updates
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == COEX_ZERO_BYTE);
    endfunction : is_zero

    function automatic logic [31:0] read_mux(input coex_state_type s,
                                             input logic [7:0] a);
        read_mux = 32'h00000000;
        case (a)
            COEX_ACC_OFS: read_mux[7:0] = s.acc;
            COEX_LATCH_OFS: read_mux[6:0] = s.latch;
            COEX_PC_OFS: read_mux[COEX_PC_W-1:0] = s.pc;
            COEX_STATUS_OFS: begin
                read_mux[COEX_ST_ZERO] = s.zero;
                read_mux[COEX_ST_TO_N] = s.to_n;
                read_mux[COEX_ST_PD_N] = s.pd_n;
                read_mux[COEX_ST_SKIP] = s.skip;
                read_mux[COEX_ST_DEPTH_LSB +: COEX_SP_W] = s.sp;
            end
            COEX_STACK_OFS: read_mux[COEX_PC_W-1:0] = s.stack[s.sp - 1'b1];
            COEX_DOG_OFS: begin
                read_mux[COEX_DOG_W-1:0] = s.dog;
                read_mux[16 +: COEX_PRE_W] = s.pre;
            end
            COEX_FADDR_OFS: read_mux[COEX_FA_W-1:0] = s.faddr;
            COEX_FDATA_OFS: read_mux[7:0] = s.file[s.faddr];
            default: read_mux = 32'h00000000;
        endcase
    endfunction : read_mux

    logic accept;
    coex_op_type op;
    logic dest;
    logic [COEX_FA_W-1:0] fa;
    logic [7:0] fval;
    logic [7:0] res;
    logic [COEX_PC_W-1:0] pc_inc;
    logic dog_clr;
    logic dog_wrap;

    assign accept = hsel && htrans[1] && hready;
    assign op = coex_op_type'(hwdata[COEX_CMD_OP_LSB +: 3]);
    assign dest = hwdata[COEX_CMD_DEST_BIT];
    assign fa = hwdata[COEX_CMD_FA_LSB +: COEX_FA_W];
    assign fval = s_r.file[fa];
    assign pc_inc = s_r.pc + 1'b1;

    always_comb begin
        s_nxt = s_r;
        res = COEX_ZERO_BYTE;
        dog_clr = 1'b0;
        dog_wrap = 1'b0;

        // free-running watchdog: prescaler carries into the count
        s_nxt.pre = s_r.pre + 1'b1;
        if (s_r.pre == {COEX_PRE_W{1'b1}}) begin
            s_nxt.dog = s_r.dog + 1'b1;
            if (s_r.dog == {COEX_DOG_W{1'b1}}) begin
                dog_wrap = 1'b1;
            end
        end

        case (s_r.bus)
            COEX_BUS_IDLE: begin
                s_nxt.hready = 1'b1;
                if (accept) begin
                    s_nxt.req.addr = haddr[7:0];
                    s_nxt.req.write = hwrite;
                    s_nxt.bus = COEX_BUS_WAIT;
                    s_nxt.hready = 1'b0;
                end
            end
            COEX_BUS_WAIT: begin
                s_nxt.bus = COEX_BUS_IDLE;
                s_nxt.hready = 1'b1;
                if (s_r.busy) begin
                    // second cycle of a call; the data phase ends now
                    s_nxt.busy = 1'b0;
                end else if (!s_r.req.write) begin
                    s_nxt.hrdata = read_mux(s_r, s_r.req.addr);
                end else begin
                    case (s_r.req.addr)
                        COEX_ACC_OFS: s_nxt.acc = hwdata[7:0];
                        COEX_LATCH_OFS: s_nxt.latch = hwdata[6:0];
                        COEX_FADDR_OFS: s_nxt.faddr = hwdata[COEX_FA_W-1:0];
                        COEX_FDATA_OFS: s_nxt.file[s_r.faddr] = hwdata[7:0];
                        COEX_CMD_OFS: begin
                            s_nxt.pc = pc_inc;
                            if (s_r.skip) begin
                                // fetched word is thrown away for a no-op
                                s_nxt.skip = 1'b0;
                            end else begin
                                case (op)
                                    COEX_OP_CLEAR_WATCHDOG: begin
                                        dog_clr = 1'b1;
                                        s_nxt.to_n = 1'b1;
                                        s_nxt.pd_n = 1'b1;
                                    end
                                    COEX_OP_CALL_ACC: begin
                                        s_nxt.stack[s_r.sp] = pc_inc;
                                        s_nxt.sp = s_r.sp + 1'b1;
                                        s_nxt.pc = {s_r.latch, s_r.acc};
                                        s_nxt.busy = 1'b1;
                                        s_nxt.bus = COEX_BUS_WAIT;
                                        s_nxt.hready = 1'b0;
                                    end
                                    COEX_OP_COMPLEMENT: begin
                                        res = ~fval;
                                        if (dest) begin
                                            s_nxt.file[fa] = res;
                                        end else begin
                                            s_nxt.acc = res;
                                        end
                                        s_nxt.zero = is_zero(res);
                                    end
                                    COEX_OP_CLEAR_FILE: begin
                                        s_nxt.file[fa] = COEX_ZERO_BYTE;
                                        s_nxt.zero = 1'b1;
                                    end
                                    COEX_OP_DECREMENT: begin
                                        res = fval - 8'h01;
                                        if (dest) begin
                                            s_nxt.file[fa] = res;
                                        end else begin
                                            s_nxt.acc = res;
                                        end
                                        s_nxt.zero = is_zero(res);
                                    end
                                    COEX_OP_CLEAR_ACC: begin
                                        s_nxt.acc = COEX_ZERO_BYTE;
                                        s_nxt.zero = 1'b1;
                                    end
                                    COEX_OP_DECREMENT_SKIP: begin
                                        // zero flag deliberately untouched
                                        res = fval - 8'h01;
                                        if (dest) begin
                                            s_nxt.file[fa] = res;
                                        end else begin
                                            s_nxt.acc = res;
                                        end
                                        s_nxt.skip = is_zero(res);
                                    end
                                    default: begin
                                    end
                                endcase
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            default: begin
                s_nxt.bus = COEX_BUS_IDLE;
                s_nxt.hready = 1'b1;
            end
        endcase

        // clear wins over the free-running increment
        if (dog_clr) begin
            s_nxt.dog = COEX_DOG_RST;
            s_nxt.pre = COEX_PRE_RST;
        end
        // an expiry in the same cycle as a clear is still reported
        if (dog_wrap) begin
            s_nxt.to_n = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.bus <= COEX_BUS_IDLE;
            s_r.hready <= 1'b1;
            s_r.to_n <= 1'b1;
            s_r.pd_n <= 1'b1;
            s_r.pc <= COEX_PC_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // hresp is a flop that never leaves okay
    logic hresp_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
        end
    end

    assign hrdata = s_r.hrdata;
    assign hreadyout = s_r.hready;
    assign hresp = hresp_r;
    assign acc = s_r.acc;
    assign zero_flag = s_r.zero;
    assign dog_expiry_status_n = s_r.to_n;
    assign sleep_entry_status_n = s_r.pd_n;
endmodule : coex_core

// *** hdl/coex_pkg.sv ***
// Purpose: constants and types for the core operation subset executor
// Assumes: one instruction cycle per clock, AHB-Lite register access
// Notes: register offsets are byte addresses of aligned 32-bit words
package coex_pkg;
    // register byte offsets
    localparam logic [7:0] COEX_CMD_OFS = 8'h00;
    localparam logic [7:0] COEX_ACC_OFS = 8'h04;
    localparam logic [7:0] COEX_LATCH_OFS = 8'h08;
    localparam logic [7:0] COEX_PC_OFS = 8'h0C;
    localparam logic [7:0] COEX_STATUS_OFS = 8'h10;
    localparam logic [7:0] COEX_STACK_OFS = 8'h14;
    localparam logic [7:0] COEX_DOG_OFS = 8'h18;
    localparam logic [7:0] COEX_FADDR_OFS = 8'h1C;
    localparam logic [7:0] COEX_FDATA_OFS = 8'h20;
    // command word fields
    localparam int COEX_CMD_OP_LSB = 0;
    localparam int COEX_CMD_DEST_BIT = 3;
    localparam int COEX_CMD_FA_LSB = 4;
    // status word fields
    localparam int COEX_ST_ZERO = 0;
    localparam int COEX_ST_TO_N = 1;
    localparam int COEX_ST_PD_N = 2;
    localparam int COEX_ST_SKIP = 3;
    localparam int COEX_ST_DEPTH_LSB = 8;
    // sizes
    localparam int COEX_PC_W = 15;
    localparam int COEX_FILE_N = 128;
    localparam int COEX_FA_W = 7;
    localparam int COEX_STACK_N = 16;
    localparam int COEX_SP_W = 4;
    localparam int COEX_PRE_W = 8;
    localparam int COEX_DOG_W = 8;
    // reset values
    localparam logic [7:0] COEX_ZERO_BYTE = 8'h00;
    localparam logic [COEX_PC_W-1:0] COEX_PC_RST = 15'h0000;
    localparam logic [COEX_PRE_W-1:0] COEX_PRE_RST = 8'h00;
    localparam logic [COEX_DOG_W-1:0] COEX_DOG_RST = 8'h00;

    typedef enum logic [2:0] {
        COEX_OP_CLEAR_WATCHDOG = 3'b000,
        COEX_OP_CALL_ACC = 3'b001,
        COEX_OP_COMPLEMENT = 3'b010,
        COEX_OP_CLEAR_FILE = 3'b011,
        COEX_OP_DECREMENT = 3'b100,
        COEX_OP_CLEAR_ACC = 3'b101,
        COEX_OP_DECREMENT_SKIP = 3'b110,
        COEX_OP_NOP = 3'b111
    } coex_op_type;

    typedef enum logic [0:0] {
        COEX_BUS_IDLE = 1'b0,
        COEX_BUS_WAIT = 1'b1
    } coex_bus_type;

    // address phase captured for the data phase
    typedef struct packed {
        logic [7:0] addr;
        logic write;
    } coex_req_type;

    typedef struct packed {
        coex_bus_type bus;
        coex_req_type req;
        logic hready;
        logic [31:0] hrdata;
        logic busy;
        logic skip;
        logic [7:0] acc;
        logic zero;
        logic to_n;
        logic pd_n;
        logic [6:0] latch;
        logic [COEX_PC_W-1:0] pc;
        logic [COEX_SP_W-1:0] sp;
        logic [COEX_STACK_N-1:0][COEX_PC_W-1:0] stack;
        logic [COEX_FA_W-1:0] faddr;
        logic [COEX_FILE_N-1:0][7:0] file;
        logic [COEX_PRE_W-1:0] pre;
        logic [COEX_DOG_W-1:0] dog;
    } coex_state_type;
endpackage : coex_pkg

// *** verif/coex_core_asserts.sv ***
// Purpose: port-level checks of the operation executor
// Assumes: hready tied to hreadyout, one transfer at a time
// Notes: ops after a decrement-skip are judged only by the call and decrement-skip stability checks, they may be discarded
`timescale 1ns/1ps
module coex_core_asserts
    import coex_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // core state
    input wire logic [7:0] acc,
    input wire logic zero_flag,
    input wire logic dog_expiry_status_n,
    input wire logic sleep_entry_status_n
);
    logic cmd_q;
    logic first_q;
    logic [2:0] last_op;
    logic ex;
    logic op_ok;
    // ex marks the first wait cycle of a command write
    assign ex = cmd_q && first_q && !hreadyout;
    assign op_ok = ex && (last_op != 3'h6);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cmd_q <= 1'b0;
            first_q <= 1'b1;
            last_op <= 3'h7;
        end else begin
            first_q <= hready;
            if (hready) begin
                cmd_q <= hsel && htrans[1] && hwrite
                    && (haddr[7:0] == COEX_CMD_OFS);
            end
            if (ex) begin
                last_op <= hwdata[2:0];
            end
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    property p_call_len;
        op_ok && hwdata[2:0] == 3'h1 |=> !hreadyout ##1 hreadyout;
    endproperty
    a_call_len: assert property (p_call_len)
        else $error("call wait length wrong");
    property p_one_wait;
        op_ok && hwdata[2:0] != 3'h1 |=> hreadyout;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("single cycle op took longer");
    property p_call_flags;
        ex && hwdata[2:0] == 3'h1 |=> ($stable(zero_flag) && $stable(acc))[*2];
    endproperty
    a_call_flags: assert property (p_call_flags)
        else $error("call changed flags or accumulator");
    property p_dog;
        op_ok && hwdata[2:0] == 3'h0
            |=> dog_expiry_status_n && sleep_entry_status_n;
    endproperty
    a_dog: assert property (p_dog)
        else $error("status bits not set by watchdog clear");
    property p_comp;
        op_ok && hwdata[3:0] == 4'h2 |=> zero_flag == (acc == 8'h00);
    endproperty
    a_comp: assert property (p_comp)
        else $error("complement zero flag wrong");
    property p_clear_file_op;
        op_ok && hwdata[2:0] == 3'h3 |=> zero_flag;
    endproperty
    a_clear_file_op: assert property (p_clear_file_op)
        else $error("file clear left zero flag low");
    property p_dec;
        op_ok && hwdata[3:0] == 4'h4 |=> zero_flag == (acc == 8'h00);
    endproperty
    a_dec: assert property (p_dec)
        else $error("decrement zero flag wrong");
    property p_clear_accumulator_op;
        op_ok && hwdata[2:0] == 3'h5 |=> acc == 8'h00 && zero_flag;
    endproperty
    a_clear_accumulator_op: assert property (p_clear_accumulator_op)
        else $error("accumulator clear wrong");
    property p_dskip;
        ex && hwdata[2:0] == 3'h6 |=> $stable(zero_flag);
    endproperty
    a_dskip: assert property (p_dskip)
        else $error("decrement-skip changed zero flag");
endmodule : coex_core_asserts

bind coex_core coex_core_asserts u_asserts (.clock(clock), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .acc(acc),
    .zero_flag(zero_flag), .dog_expiry_status_n(dog_expiry_status_n),
    .sleep_entry_status_n(sleep_entry_status_n));

// *** verif/tb.sv ***
// Purpose: self-checking bench for the operation executor
// Assumes: AHB-Lite single word transfers, hready tied to hreadyout
// Notes: one full watchdog wrap is run, it dominates the run time
`timescale 1ns/1ps
module tb
    import coex_pkg::*;
;
    `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
        n_errors++; $display("unexpected at %0t: got %h want %h", \
        $time, (a), (e)); end end
    logic clock, rstn, hsel, hwrite;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, q;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, zf, ton, pdn;
    wire logic [7:0] acc;
    int n_errors, comparisons, cycles;
    coex_core uut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .acc(acc), .zero_flag(zf),
        .dog_expiry_status_n(ton), .sleep_entry_status_n(pdn));
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // entered just after a rising edge; the timeout ends any hang
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic cmd(input logic [2:0] op, input logic d,
                       input logic [6:0] fa);
        bus(1'b1, COEX_CMD_OFS, {21'h000000, fa, d, op});
    endtask : cmd
    task automatic t_dog;
        repeat (600) @(posedge clock);
        cmd(3'h0, 1'b0, 7'h00);
        bus(1'b0, COEX_DOG_OFS, 32'h0);
        `CHK(q[7:0], 8'h00)
        `CHK(q[23:16] < 8'h08, 1'b1)
        bus(1'b0, COEX_STATUS_OFS, 32'h0);
        `CHK(q[2:1], 2'b11)
        // let the count wrap so the timeout bit really drops
        repeat (65600) @(posedge clock);
        `CHK(ton, 1'b0)
        cmd(3'h0, 1'b0, 7'h00);
        `CHK(ton, 1'b1)
    endtask : t_dog
    task automatic t_call;
        logic [31:0] p0;
        bus(1'b1, COEX_ACC_OFS, 32'h0000005A);
        bus(1'b1, COEX_LATCH_OFS, 32'h00000013);
        bus(1'b0, COEX_PC_OFS, 32'h0);
        p0 = q;
        cmd(3'h1, 1'b0, 7'h00);
        bus(1'b0, COEX_PC_OFS, 32'h0);
        `CHK(q, 32'h0000135A)
        bus(1'b0, COEX_STACK_OFS, 32'h0);
        `CHK(q, p0 + 32'h1)
        bus(1'b0, COEX_STATUS_OFS, 32'h0);
        `CHK(q[11:8], 4'h1)
    endtask : t_call
    // row: op, dest, file before, result, zero flag
    task automatic t_rows;
        logic [27:0] rows [0:5] = '{28'h4001001, 28'h4100FF0, 28'h3177001,
            28'h2000FF0, 28'h5012001, 28'h21F00F0};
        logic [6:0] fa;
        for (int i = 0; i < 6; i++) begin
            fa = i[0] ? 7'h7F : 7'h00;
            bus(1'b1, COEX_FADDR_OFS, {25'h0, fa});
            bus(1'b1, COEX_FDATA_OFS, {24'h0, rows[i][19:12]});
            bus(1'b1, COEX_ACC_OFS, 32'h00000033);
            cmd(rows[i][26:24], rows[i][20], fa);
            `CHK(zf, rows[i][0])
            `CHK(acc, rows[i][20] ? 8'h33 : rows[i][11:4])
            bus(1'b0, COEX_FDATA_OFS, 32'h0);
            `CHK(q[7:0], rows[i][20] ? rows[i][11:4] : rows[i][19:12])
        end
    endtask : t_rows
    task automatic t_skip;
        logic [31:0] p0;
        bus(1'b1, COEX_FADDR_OFS, 32'h5);
        bus(1'b1, COEX_FDATA_OFS, 32'h2);
        cmd(3'h5, 1'b0, 7'h00);
        cmd(3'h6, 1'b1, 7'h05);
        `CHK(zf, 1'b1)
        bus(1'b0, COEX_FDATA_OFS, 32'h0);
        `CHK(q[7:0], 8'h01)
        // complement drops the flag and leaves the file at one
        cmd(3'h2, 1'b0, 7'h05);
        cmd(3'h6, 1'b0, 7'h05);
        `CHK(acc, 8'h00)
        `CHK(zf, 1'b0)
        bus(1'b1, COEX_ACC_OFS, 32'h00000044);
        bus(1'b0, COEX_PC_OFS, 32'h0);
        p0 = q;
        cmd(3'h5, 1'b0, 7'h00);
        `CHK(acc, 8'h44)
        cmd(3'h5, 1'b0, 7'h00);
        `CHK(acc, 8'h00)
        bus(1'b0, COEX_PC_OFS, 32'h0);
        `CHK(q, p0 + 32'h2)
    endtask : t_skip
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // hang guard: the whole run needs about 66400 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles > 70000) begin
            n_errors++;
            report_and_stop();
        end
    end
    initial begin
        rstn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        t_dog();
        t_call();
        t_rows();
        t_skip();
        report_and_stop();
    end
endmodule : tb
